// [tsq_pkg.sv]
package tsq_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_C1LIM   = 8'h00;
	localparam logic [7:0] ADDR_ADJ     = 8'h04;
	localparam logic [7:0] ADDR_LIT     = 8'h08;
	localparam logic [7:0] ADDR_QPTR    = 8'h0C;
	localparam logic [7:0] ADDR_T0LIM   = 8'h10;
	localparam logic [7:0] ADDR_T1LIM   = 8'h14;
	localparam logic [7:0] ADDR_C0LIM   = 8'h18;
	localparam logic [7:0] ADDR_SDLIM   = 8'h1C;
	localparam logic [7:0] ADDR_CMD     = 8'h20;
	localparam logic [7:0] ADDR_STAT    = 8'h24;
	localparam logic [7:0] ADDR_QUE0    = 8'h40;
	localparam logic [7:0] ADDR_QUE_END = 8'h60;

	// ------------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------------
	localparam int          LIM_W      = 16;
	localparam int          QPTR_W     = 5;
	localparam int          QWORDS     = 8;
	localparam int          OUT_W      = 32;
	localparam logic [15:0] LIM_RESET  = 16'h0000;
	localparam logic [4:0]  QPTR_RESET = 5'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	// Command register fields.
	localparam int CMD_GO_BIT    = 0;
	localparam int CMD_STEP_LSB  = 8;
	localparam int CMD_TGT_LSB   = 16;
	localparam int CMD_OUT_LSB   = 24;

	// Step kinds understood by the small executor.
	localparam logic [1:0] STEP_ADD    = 2'h0;
	localparam logic [1:0] STEP_STROBE = 2'h1;
	localparam logic [1:0] STEP_TRIG   = 2'h2;
	localparam logic [1:0] STEP_NOP    = 2'h3;

	// Add-step targets.
	localparam logic [2:0] TGT_T0  = 3'h0;
	localparam logic [2:0] TGT_T1  = 3'h1;
	localparam logic [2:0] TGT_C0  = 3'h2;
	localparam logic [2:0] TGT_C1  = 3'h3;
	localparam logic [2:0] TGT_SD  = 3'h4;
	localparam logic [2:0] TGT_LIT = 3'h5;

	// Trigger output lanes.
	localparam int OUT_CAP     = 9;
	localparam int OUT_ADC_LO  = 12;
	localparam int OUT_ADC_HI  = 15;
	localparam int OUT_PIN_LO  = 28;
	localparam int OUT_PIN_HI  = 31;

	typedef struct packed {
		logic [1:0] kind;
		logic [2:0] target;
		logic [4:0] lane;
	} tsq_step_t;

endpackage

// [tsq_step_timer.sv]
`timescale 1ns/1ps
module tsq_step_timer
#(
	parameter int WIDTH = 16
)
(
	input  wire logic             pclk,      // Sequencer clock.
	input  wire logic             presetn,   // Async reset, low.
	input  wire logic             start,     // Begin a step.
	input  wire logic [WIDTH-1:0] extra,     // Additional clocks.
	output logic                  busy,      // Step in progress.
	output logic                  done       // Last step clock.
);

	if (WIDTH < 1)
	begin : g_bad_width
		$error("tsq_step_timer: WIDTH must be positive");
	end

	logic [WIDTH-1:0] cnt_ff;

	// A step lasts one clock plus the programmed extra clocks.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_ff <= '0;
			busy   <= 1'b0;
		end
		else if (start && !busy)
		begin
			cnt_ff <= extra; // [RULE_10]
			busy   <= 1'b1;
		end
		else if (busy)
		begin
			if (cnt_ff == '0)
				busy <= 1'b0;
			else
				cnt_ff <= cnt_ff - 1'b1; // [RULE_10]
		end
	end

	assign done = busy && (cnt_ff == '0);

endmodule

// [tsq_queue_mem.sv]
`timescale 1ns/1ps
module tsq_queue_mem
#(
	parameter int WORDS = 8
)
(
	input  wire logic                     pclk,    // Sequencer clock.
	input  wire logic                     presetn, // Async reset, low.
	input  wire logic                     wr_en,   // Word write strobe.
	input  wire logic [$clog2(WORDS)-1:0] wr_idx,  // Word index.
	input  wire logic [31:0]              wr_data, // Word data.
	input  wire logic [$clog2(WORDS)-1:0] rd_idx,  // Bus read index.
	output logic      [31:0]              rd_data, // Bus read word.
	input  wire logic [4:0]               ptr,     // Step pointer.
	output logic      [7:0]               step     // Active step byte.
);
	import tsq_pkg::*;

	// The 5-bit pointer spans exactly 32 step bytes.
	if (WORDS * 4 != 32)
	begin : g_bad_words
		$error("tsq_queue_mem: pointer spans exactly 32 bytes");
	end

	logic [31:0] que_ff [WORDS];
	logic [31:0] sel_word;

	genvar gi;
	generate
		for (gi = 0; gi < WORDS; gi++)
		begin : g_word
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					que_ff[gi] <= WORD_RESET; // [RULE_12]
				else if (wr_en && wr_idx == gi)
					que_ff[gi] <= wr_data; // [RULE_05]
			end
		end
	endgenerate

	assign rd_data  = que_ff[rd_idx];
	assign sel_word = que_ff[ptr[4:2]];
	// Byte 4n sits in the low lane, 4n+3 in the top lane.
	assign step = sel_word[{ptr[1:0], 3'b000} +: 8]; // [RULE_06]

endmodule

// [tsq_regs.sv]
// Operation
// [RULE_01] Counter one limit is the loop count for the jump-on-counter-one step or a general limit.
// [RULE_02] An add step adds the 16-bit adjust value to a chosen limit or the literal and writes it back.
// [RULE_03] A 16-bit literal is held and driven on the strobe output when the strobe step runs.
// [RULE_04] A 5-bit software-writable pointer selects the active step command in the queue.
// [RULE_05] Eight 32-bit queue words hold four step bytes each, byte 4n+3 in the top lane.
// [RULE_06] Word n holds byte 4n in bits 7-0, 4n+1 in bits 15-8 and 4n+2 in bits 23-16.
// [RULE_07] Outputs 12 to 15 are ADC sample triggers, output 9 feeds capacitive sensing.
// [RULE_08] Outputs 28 to 31 are output buffer data lines for pin selection.
// [RULE_09] Unimplemented bits read as zero and ignore writes.
// [RULE_10] Each step lasts one clock plus the step delay limit in extra clocks.
// [RULE_11] Counter zero limit is the loop count for the jump-on-counter-zero step or a general limit.
// [RULE_12] All implemented bits clear to zero on reset; the STAT state field resets to ST_IDLE (3'b001), so STAT bit 0 reads as one.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module tsq_regs
#(
	parameter int QWORDS_P = tsq_pkg::QWORDS
)
(
	input  wire logic                       pclk,      // Sequencer clock.
	input  wire logic                       presetn,   // Async reset, low.
	input  wire logic                       psel,      // APB select.
	input  wire logic                       penable,   // APB enable.
	input  wire logic                       pwrite,    // APB write.
	input  wire logic [7:0]                 paddr,     // APB address.
	input  wire logic [31:0]                pwdata,    // APB write data.
	output logic      [31:0]                prdata,    // APB read data.
	output logic                            pready,    // APB ready.
	output logic                            pslverr,   // APB error.
	output logic [tsq_pkg::LIM_W-1:0]       strobe_data,   // Literal.
	output logic                            strobe_valid,  // Literal strobe.
	output logic [3:0]                      adc_trigger,   // ADC triggers.
	output logic                            cap_trigger,   // Cap sensing.
	output logic [3:0]                      pin_data,      // To pin select.
	output logic [tsq_pkg::LIM_W-1:0]       count_zero_lim,// Loop limit 0.
	output logic [tsq_pkg::LIM_W-1:0]       count_one_lim  // Loop limit 1.
);
	import tsq_pkg::*;

	// The register map has room for exactly this many queue words.
	if (QWORDS_P != QWORDS)
	begin : g_bad_depth
		$error("tsq_regs: queue depth is fixed by the map");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_DONE = 3'b100
	} tsq_state_t;

	tsq_state_t state_ff;
	tsq_state_t nxt_state;

	logic [LIM_W-1:0]  c1lim_ff;
	logic [LIM_W-1:0]  c0lim_ff;
	logic [LIM_W-1:0]  t0lim_ff;
	logic [LIM_W-1:0]  t1lim_ff;
	logic [LIM_W-1:0]  sdlim_ff;
	logic [LIM_W-1:0]  adj_ff;
	logic [LIM_W-1:0]  lit_ff;
	logic [QPTR_W-1:0] qptr_ff;
	tsq_step_t         step_ff;
	logic [OUT_W-1:0]  out_ff;
	logic              strobe_ff;
	logic [31:0]       prdata_ff;
	logic              pslverr_ff;

	logic              acc;
	logic              wr;
	logic              is_que;
	logic              mapped;
	logic [2:0]        que_idx;
	logic [31:0]       que_rd;
	logic [7:0]        step_byte;
	logic              tm_busy;
	logic              tm_done;
	logic              go;
	logic [LIM_W-1:0]  sum;
	logic [LIM_W-1:0]  tgt_val;
	logic              do_add;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	assign acc     = psel && penable;
	assign wr      = acc && pwrite;
	assign is_que  = (paddr >= ADDR_QUE0) && (paddr < ADDR_QUE_END);
	assign que_idx = paddr[4:2];
	// A go write is ignored unless the executor is idle.
	assign go      = wr && (paddr == ADDR_CMD) && pwdata[CMD_GO_BIT]
			&& (state_ff == ST_IDLE);

	always_comb
	begin
		case (paddr)
			ADDR_C1LIM, ADDR_ADJ, ADDR_LIT, ADDR_QPTR, ADDR_T0LIM,
			ADDR_T1LIM, ADDR_C0LIM, ADDR_SDLIM, ADDR_CMD, ADDR_STAT:
				mapped = (paddr[1:0] == 2'b00);
			default:
				mapped = is_que && (paddr[1:0] == 2'b00);
		endcase
	end

	// ------------------------------------------------------------------
	// Queue storage
	// ------------------------------------------------------------------
	tsq_queue_mem #(
		.WORDS   (QWORDS_P)
	) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr && is_que && mapped),
		.wr_idx  (que_idx),
		.wr_data (pwdata),
		.rd_idx  (que_idx),
		.rd_data (que_rd),
		.ptr     (qptr_ff),
		.step    (step_byte)
	);

	// The timer, started in the first RUN clock, holds RUN for one more clock plus the step delay limit.
	tsq_step_timer #(
		.WIDTH   (LIM_W)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (state_ff == ST_RUN),
		.extra   (sdlim_ff),
		.busy    (tm_busy),
		.done    (tm_done)
	);

	// ------------------------------------------------------------------
	// Add step arithmetic
	// ------------------------------------------------------------------
	always_comb
	begin
		case (step_ff.target)
			TGT_T0:  tgt_val = t0lim_ff;
			TGT_T1:  tgt_val = t1lim_ff;
			TGT_C0:  tgt_val = c0lim_ff;
			TGT_C1:  tgt_val = c1lim_ff;
			TGT_SD:  tgt_val = sdlim_ff;
			TGT_LIT: tgt_val = lit_ff;
			default: tgt_val = '0;
		endcase
	end

	// The add result lands in the DONE cycle; a bus write to any limit,
	// adjust or literal register in that cycle is lost.
	assign sum    = LIM_W'(tgt_val + adj_ff); // [RULE_02]
	assign do_add = (state_ff == ST_DONE) && (step_ff.kind == STEP_ADD);

	// ------------------------------------------------------------------
	// Step state machine
	// ------------------------------------------------------------------
	always_comb
	begin
		case (state_ff)
			ST_IDLE: nxt_state = go ? ST_RUN : ST_IDLE;
			ST_RUN:  nxt_state = (tm_busy && tm_done) ? ST_DONE : ST_RUN;
			ST_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state; // [RULE_10]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			step_ff <= '0;
		else if (go)
			step_ff <= pwdata[CMD_STEP_LSB +: 10];
	end

	// ------------------------------------------------------------------
	// Software registers, add write-back wins over a bus write
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			c1lim_ff <= LIM_RESET; // [RULE_12]
			c0lim_ff <= LIM_RESET;
			t0lim_ff <= LIM_RESET;
			t1lim_ff <= LIM_RESET;
			sdlim_ff <= LIM_RESET;
			adj_ff   <= LIM_RESET;
			lit_ff   <= LIM_RESET;
		end
		else if (do_add)
		begin
			case (step_ff.target)
				TGT_T0:  t0lim_ff <= sum; // [RULE_02]
				TGT_T1:  t1lim_ff <= sum;
				TGT_C0:  c0lim_ff <= sum;
				TGT_C1:  c1lim_ff <= sum;
				TGT_SD:  sdlim_ff <= sum;
				TGT_LIT: lit_ff   <= sum;
				default: lit_ff   <= lit_ff;
			endcase
		end
		else if (wr)
		begin
			// Only the low half is kept; upper bits are dropped.
			case (paddr)
				ADDR_C1LIM: c1lim_ff <= pwdata[LIM_W-1:0]; // [RULE_09]
				ADDR_C0LIM: c0lim_ff <= pwdata[LIM_W-1:0];
				ADDR_T0LIM: t0lim_ff <= pwdata[LIM_W-1:0];
				ADDR_T1LIM: t1lim_ff <= pwdata[LIM_W-1:0];
				ADDR_SDLIM: sdlim_ff <= pwdata[LIM_W-1:0];
				ADDR_ADJ:   adj_ff   <= pwdata[LIM_W-1:0];
				ADDR_LIT:   lit_ff   <= pwdata[LIM_W-1:0];
				default:    adj_ff   <= adj_ff;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			qptr_ff <= QPTR_RESET;
		else if (wr && paddr == ADDR_QPTR)
			qptr_ff <= pwdata[QPTR_W-1:0]; // [RULE_04]
	end

	// ------------------------------------------------------------------
	// Outputs: strobe and trigger lanes
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strobe_ff   <= 1'b0;
			strobe_data <= '0;
		end
		else
		begin
			strobe_ff <= (state_ff == ST_DONE)
					&& (step_ff.kind == STEP_STROBE);
			if ((state_ff == ST_DONE) && (step_ff.kind == STEP_STROBE))
				strobe_data <= lit_ff; // [RULE_03]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_ff <= '0;
		else if ((state_ff == ST_DONE) && (step_ff.kind == STEP_TRIG))
			out_ff <= OUT_W'(1) << step_ff.lane;
		else
			out_ff <= '0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_trigger    <= '0;
			cap_trigger    <= 1'b0;
			pin_data       <= '0;
			strobe_valid   <= 1'b0;
			count_zero_lim <= '0;
			count_one_lim  <= '0;
		end
		else
		begin
			adc_trigger    <= out_ff[OUT_ADC_HI:OUT_ADC_LO]; // [RULE_07]
			cap_trigger    <= out_ff[OUT_CAP]; // [RULE_07]
			pin_data       <= out_ff[OUT_PIN_HI:OUT_PIN_LO]; // [RULE_08]
			strobe_valid   <= strobe_ff;
			count_zero_lim <= c0lim_ff; // [RULE_11]
			count_one_lim  <= c1lim_ff; // [RULE_01]
		end
	end

	// ------------------------------------------------------------------
	// Read mux, no wait states
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff  <= WORD_RESET;
		end
		else if (psel && !penable)
		begin
			// An unaligned queue address reads as zero like any hole.
			if (is_que && mapped)
				prdata_ff <= que_rd;
			else
			begin
				case (paddr)
					ADDR_C1LIM: prdata_ff <= {16'h0000, c1lim_ff}; // [RULE_09]
					ADDR_C0LIM: prdata_ff <= {16'h0000, c0lim_ff};
					ADDR_T0LIM: prdata_ff <= {16'h0000, t0lim_ff};
					ADDR_T1LIM: prdata_ff <= {16'h0000, t1lim_ff};
					ADDR_SDLIM: prdata_ff <= {16'h0000, sdlim_ff};
					ADDR_ADJ:   prdata_ff <= {16'h0000, adj_ff};
					ADDR_LIT:   prdata_ff <= {16'h0000, lit_ff};
					ADDR_QPTR:  prdata_ff <= {27'h000_0000, qptr_ff};
					ADDR_STAT:  prdata_ff <= {21'h00_0000, step_byte,
							state_ff};
					default:    prdata_ff <= WORD_RESET;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	// The error flag is registered so that it stands with pready alone.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr_ff <= 1'b0;
		else
			pslverr_ff <= psel && !penable && !mapped; // [RULE_09]
	end

	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

endmodule

// [tsq_props.sv]
`timescale 1ns/1ps
module tsq_props
(
	input wire logic                        pclk,           // Clock.
	input wire logic                        presetn,        // Reset.
	input wire logic                        psel,           // Select.
	input wire logic                        penable,        // Enable.
	input wire logic                        pwrite,         // Write.
	input wire logic [7:0]                  paddr,          // Address.
	input wire logic [31:0]                 pwdata,         // Wdata.
	input wire logic [31:0]                 prdata,         // Rdata.
	input wire logic                        pready,         // Ready.
	input wire logic                        pslverr,        // Error.
	input wire logic [tsq_pkg::LIM_W-1:0]   strobe_data,    // Literal.
	input wire logic                        strobe_valid,   // Strobe.
	input wire logic [3:0]                  adc_trigger,    // ADC.
	input wire logic                        cap_trigger,    // Sensing.
	input wire logic [3:0]                  pin_data,       // Pins.
	input wire logic [tsq_pkg::LIM_W-1:0]   count_zero_lim, // Limit 0.
	input wire logic [tsq_pkg::LIM_W-1:0]   count_one_lim   // Limit 1.
);
	import tsq_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_access: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_limit_upper: assert property (pready && !pwrite
		&& paddr < ADDR_QPTR |-> prdata[31:16] == 16'h0)
		else $error("limit upper bits set");
	a_qptr_upper: assert property (pready && !pwrite
		&& paddr == ADDR_QPTR |-> prdata[31:5] == 27'h0)
		else $error("pointer upper bits set");
	a_err_zero: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0) else $error("refused read not zero");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	a_lit_strobed: assert property ($changed(strobe_data)
		|-> ##[0:1] strobe_valid) else $error("literal changed unstrobed");
	a_strobe_pulse: assert property (
		strobe_valid |=> !strobe_valid)
		else $error("strobe longer than one cycle");
	a_adc_pulse: assert property (
		|adc_trigger |=> adc_trigger == 4'h0)
		else $error("adc trigger not a pulse");
	a_pin_pulse: assert property (
		|pin_data |=> pin_data == 4'h0)
		else $error("pin data not a pulse");
	a_one_lane: assert property (
		$onehot0({pin_data, adc_trigger, cap_trigger}))
		else $error("several trigger lanes at once");

	c_strobe: cover property (strobe_valid);
	c_cap: cover property (cap_trigger);
	c_refused: cover property (pready && pslverr);
endmodule

// [tsq_far_end.sv]
`timescale 1ns/1ps
module tsq_far_end
(
	input  wire logic       pclk,        // Clock.
	input  wire logic       presetn,     // Reset, low.
	input  wire logic [3:0] adc_trigger, // Sample triggers.
	input  wire logic       cap_trigger, // Sensing trigger.
	input  wire logic [3:0] pin_data,    // Pin select data.
	output int              n_out,       // Pulses seen.
	output logic [4:0]      last_lane    // Lane of last pulse.
);
	// ------------------------------------------------------------------
	// Converter, sensing and pin routing seen as one pulse counter.
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			n_out <= 0;
			last_lane <= 5'h0;
		end
		else if (|{adc_trigger, cap_trigger, pin_data})
		begin
			n_out <= n_out + 1;
			for (int i = 0; i < 4; i++)
			begin
				if (adc_trigger[i])
					last_lane <= 5'(12 + i);
				if (pin_data[i])
					last_lane <= 5'(28 + i);
			end
			if (cap_trigger)
				last_lane <= 5'h9;
		end
	end
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
	import tsq_pkg::*;
	logic              pclk, presetn, psel, penable, pwrite, err;
	logic              pready, pslverr, strobe_valid, cap_trigger;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rd, seed, d0, ex;
	logic [LIM_W-1:0]  strobe_data, count_zero_lim, count_one_lim, lit_seen;
	logic [3:0]        adc_trigger, pin_data;
	logic [4:0]        last_lane;
	logic [31:0]       m_reg [8];
	logic [31:0]       m_que [8];
	int                n_errors, n_checks, cyc, t_out, t_go, n_out, n0;
	localparam logic [7:0] TADDR [6] = '{ADDR_T0LIM, ADDR_T1LIM,
		ADDR_C0LIM, ADDR_C1LIM, ADDR_SDLIM, ADDR_LIT};
	localparam logic [4:0] LANES [11] = '{5'h09, 5'h0c, 5'h0d, 5'h0e,
		5'h0f, 5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h03, 5'h14};

	tsq_regs tsq_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strobe_data(strobe_data), .strobe_valid(strobe_valid),
		.adc_trigger(adc_trigger), .cap_trigger(cap_trigger),
		.pin_data(pin_data), .count_zero_lim(count_zero_lim),
		.count_one_lim(count_one_lim));
	tsq_far_end tsq_far_end_i (.pclk(pclk), .presetn(presetn),
		.adc_trigger(adc_trigger), .cap_trigger(cap_trigger),
		.pin_data(pin_data), .n_out(n_out), .last_lane(last_lane));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (strobe_valid)
			lit_seen <= strobe_data;
		if (|{adc_trigger, cap_trigger, pin_data})
			t_out <= cyc;
	end

	// ------------------------------------------------------------------
	// Bus, model and comparison helpers.
	// ------------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a < ADDR_CMD && a[1:0] == 2'h0)
			m_reg[a[4:2]] = d & (a == ADDR_QPTR ? 32'h1f : 32'hffff);
		else if (a >= ADDR_QUE0 && a < ADDR_QUE_END && a[1:0] == 2'h0)
			m_que[a[4:2]] = d;
	endtask

	function automatic logic [31:0] mexp(input logic [7:0] a);
		return (a >= ADDR_QUE0) ? m_que[a[4:2]] : m_reg[a[4:2]];
	endfunction

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task draw;
		repeat (7) seed = lfsr(seed);
	endtask

	task step(input logic [1:0] kind, input logic [2:0] tgt,
		input logic [4:0] lane);
		tsq_step_t s;
		int k;
		s = {kind, tgt, lane};
		apb(1'b1, ADDR_CMD, {14'h0, s, 8'h01});
		t_go = cyc;
		k = 0;
		rd = 32'h0;
		while (rd[2:0] !== 3'h1 && k < 200)
		begin
			apb(1'b0, ADDR_STAT, 32'h0);
			k++;
		end
		repeat (4) @(posedge pclk);
	endtask

	task give_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge pclk);
		n_errors++;
		give_verdict;
	end

	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		seed = 32'h4e;
		cyc = 0;
		t_out = 0;
		for (int i = 0; i < 8; i++)
		begin
			m_reg[i] = 32'h0;
			m_que[i] = 32'h0;
		end
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b0, (i < 8) ? 8'(i * 4) : 8'(ADDR_QUE0 + (i - 8) * 4), 0);
			chk(rd, 32'h0);
			chk(32'(err), 32'h0);
		end
		for (int i = 0; i < 8; i++)
		begin
			draw;
			wr(8'(i * 4), (i == 7) ? (seed & 32'hffff_000f) : seed);
			apb(1'b0, 8'(i * 4), 0);
			chk(rd, m_reg[i]);
		end
		chk(32'(count_one_lim), m_reg[0]);
		chk(32'(count_zero_lim), m_reg[6]);
		for (int i = 0; i < 3; i++)
		begin
			draw;
			apb(1'b1, (i == 0) ? 8'h30 : (i == 1) ? 8'h02 : 8'h64, seed);
			chk(32'(err), 32'h1);
			apb(1'b0, 8'h30, 0);
			chk(rd, 32'h0);
			apb(1'b0, ADDR_C1LIM, 0);
			chk(rd, m_reg[0]);
		end
		for (int n = 0; n < 8; n++)
		begin
			draw;
			wr(8'(ADDR_QUE0 + n * 4), seed);
		end
		for (int p = 0; p < 32; p++)
		begin
			draw;
			wr(ADDR_QPTR, {seed[31:5], 5'(p)});
			apb(1'b0, ADDR_QPTR, 0);
			chk(rd, m_reg[3]);
			apb(1'b0, ADDR_STAT, 0);
			ex = (m_que[p / 4] >> (8 * (p % 4))) & 32'hff;
			chk(32'(rd[10:3]), ex);
		end
		for (int n = 0; n < 8; n++)
		begin
			apb(1'b0, 8'(ADDR_QUE0 + n * 4), 0);
			chk(rd, m_que[n]);
		end
		for (int t = 0; t < 6; t++)
		begin
			draw;
			wr(ADDR_ADJ, (t == int'(TGT_SD)) ? 32'h3 : seed);
			step(STEP_ADD, 3'(t), 5'h0);
			ex = m_reg[TADDR[t][4:2]] + m_reg[1];
			m_reg[TADDR[t][4:2]] = ex & 32'hffff;
			apb(1'b0, TADDR[t], 0);
			chk(rd, m_reg[TADDR[t][4:2]]);
		end
		for (int i = 0; i < 2; i++)
		begin
			draw;
			if (i == 1)
				wr(ADDR_LIT, seed);
			step(STEP_STROBE, 3'h0, 5'h0);
			chk(32'(lit_seen), m_reg[2]);
		end
		wr(ADDR_SDLIM, 32'h0);
		for (int i = 0; i < 11; i++)
		begin
			n0 = n_out;
			step(STEP_TRIG, 3'h0, LANES[i]);
			chk(32'(n_out - n0), (i < 9) ? 32'h1 : 32'h0);
			if (i < 9)
				chk(32'(last_lane), 32'(LANES[i]));
			if (i == 0)
				d0 = 32'(t_out - t_go);
		end
		n0 = n_out;
		step(STEP_NOP, 3'h0, 5'h0c);
		chk(32'(n_out - n0), 32'h0);
		wr(ADDR_SDLIM, 32'h5);
		step(STEP_TRIG, 3'h0, 5'h0c);
		chk(32'(t_out - t_go) - d0, 32'h5);
		give_verdict;
	end
endmodule

bind tsq_regs tsq_props tsq_props_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.strobe_data(strobe_data), .strobe_valid(strobe_valid),
	.adc_trigger(adc_trigger), .cap_trigger(cap_trigger),
	.pin_data(pin_data), .count_zero_lim(count_zero_lim),
	.count_one_lim(count_one_lim));
